// ===== ddc_device.sv
`timescale 1ns/1ps
module ddc_device #(
    parameter int SMP_W = 14
) (
    input wire logic clk_sys,
    input wire logic rst,
    ddc_link_if.dev link
);
    import ddc_cfg_pkg::*;

    if (SMP_W < 4 || SMP_W > 16)
    begin : gen_bad_smp_w
        $error("SMP_W must be 4..16");
    end

    typedef struct packed {
        logic [7:0] mode_bc;
        logic [7:0] bc_filt;
        logic [7:0] ad;
        logic [7:0] il_byp;
        logic [7:0] dc_loop;
        logic il_rst_seen;
        logic [7:0] rdata;
        logic [3:0][3:0] ph;
        logic [3:0][15:0] dc;
        logic [3:0][15:0] il;
        logic smp_odd;
        logic [1:0] dcnt;
        logic [3:0][17:0] acc_i;
        logic [3:0][17:0] acc_q;
        logic [3:0] ovalid;
        logic [3:0][15:0] oi;
        logic [3:0][15:0] oq;
    } dev_state_t;

    dev_state_t s_ff;
    dev_state_t nxt_s;

    function automatic logic signed [15:0] mul_lo(input logic signed [15:0] x,
        input logic signed [7:0] c);
        logic signed [23:0] p;
        p = x * c;
        mul_lo = p[22:7];
    endfunction : mul_lo

    // true when channel belongs to the A/D pair
    function automatic logic pair_ad(input int ch);
        pair_ad = (ch == 0) || (ch == 3);
    endfunction : pair_ad

    logic [3:0] mode;
    logic [1:0] il_field;
    logic [1:0] dc_field;
    logic mix_on;
    logic [1:0] dec_last;
    logic [7:0] waddr;

    always_comb
    begin
        logic signed [15:0] x;
        logic signed [15:0] xc;
        logic signed [16:0] t;
        logic signed [15:0] mi;
        logic signed [15:0] mq;
        logic signed [17:0] si;
        logic signed [17:0] sq;
        logic [3:0] step;
        logic coarse;
        logic hp;
        x = '0;
        xc = '0;
        t = '0;
        mi = '0;
        mq = '0;
        si = '0;
        sq = '0;
        step = '0;
        coarse = 1'b0;
        hp = 1'b0;
        nxt_s = s_ff;
        mode = s_ff.mode_bc[MODE_LSB +: 4];
        il_field = s_ff.il_byp[IL_LSB +: 2];
        dc_field = s_ff.dc_loop[DC_LSB +: 2];
        mix_on = (mode == MODE_QUARTER) || (mode == MODE_FINE_REAL)
            || (mode == MODE_FINE_CPLX) || (mode == MODE_FINE_DEC4) || (mode == MODE_FINE_ZERO);
        dec_last = (mode == MODE_FINE_DEC4) ? 2'd3 : ((mode == MODE_PASS) ? 2'd0 : 2'd1);
        waddr = link.cfg_addr[7:0];
        nxt_s.ovalid = '0;
        nxt_s.rdata = '0;

        // reserved positions are masked on write and so read back zero
        if (link.cfg_wr)
        begin
            if (link.cfg_addr[PAGE_BIT])
            begin
                case (waddr)
                    OFS_MODE_BC: nxt_s.mode_bc = link.cfg_wdata & MASK_MODE_BC;
                    OFS_BC_FILT: nxt_s.bc_filt = link.cfg_wdata & MASK_BC_FILT;
                    OFS_AD: nxt_s.ad = link.cfg_wdata & MASK_AD;
                    default: ;
                endcase
            end
            else
            begin
                case (waddr)
                    OFS_IL_BYP: nxt_s.il_byp = link.cfg_wdata & MASK_IL_BYP;
                    OFS_DC_LOOP: nxt_s.dc_loop = link.cfg_wdata & MASK_DC_LOOP;
                    default: ;
                endcase
            end
        end
        if (link.cfg_rd)
        begin
            if (link.cfg_addr[PAGE_BIT])
            begin
                case (waddr)
                    OFS_MODE_BC: nxt_s.rdata = s_ff.mode_bc;
                    OFS_BC_FILT: nxt_s.rdata = s_ff.bc_filt;
                    OFS_AD: nxt_s.rdata = s_ff.ad;
                    default: nxt_s.rdata = '0;
                endcase
            end
            else
            begin
                case (waddr)
                    OFS_IL_BYP: nxt_s.rdata = s_ff.il_byp;
                    OFS_DC_LOOP: nxt_s.rdata = s_ff.dc_loop;
                    default: nxt_s.rdata = '0;
                endcase
            end
        end

        if (link.smp_valid)
        begin
            nxt_s.smp_odd = ~s_ff.smp_odd;
            nxt_s.dcnt = (s_ff.dcnt >= dec_last) ? 2'd0 : s_ff.dcnt + 2'd1;
            for (int ch = 0; ch < 4; ch++)
            begin
                x = 16'(signed'(link.smp[ch]));
                xc = x;
                // even/odd mismatch estimate, half applied with opposite sign per phase
                if (il_field == CORR_ON)
                begin
                    t = s_ff.smp_odd ? 17'(x) - 17'(signed'(s_ff.il[ch]))
                        : -17'(x) - 17'(signed'(s_ff.il[ch]));
                    nxt_s.il[ch] = 16'(signed'(s_ff.il[ch]) + (t >>> IL_SHIFT));
                    xc = s_ff.smp_odd ? 16'(xc - (signed'(s_ff.il[ch]) >>> 1))
                        : 16'(xc + (signed'(s_ff.il[ch]) >>> 1));
                end
                // dc estimator only adapts while the loop runs; 01/10 leave it stopped
                if (dc_field == CORR_ON)
                begin
                    t = 17'(x) - 17'(signed'(s_ff.dc[ch]));
                    nxt_s.dc[ch] = 16'(signed'(s_ff.dc[ch]) + (t >>> DC_SHIFT));
                    xc = 16'(xc - signed'(s_ff.dc[ch]));
                end
                coarse = pair_ad(ch) ? s_ff.ad[AD_COARSE_BIT] : s_ff.bc_filt[BC_COARSE_BIT];
                hp = pair_ad(ch) ? s_ff.ad[AD_HP_BIT] : s_ff.bc_filt[BC_HP_BIT];
                if (mode == MODE_QUARTER)
                begin
                    step = coarse ? QUARTER_NEG : QUARTER_POS;
                end
                else
                begin
                    step = pair_ad(ch) ? s_ff.ad[AD_TUNE_LSB +: 4]
                        : s_ff.mode_bc[BC_TUNE_LSB +: 4];
                end
                nxt_s.ph[ch] = s_ff.ph[ch] + step;
                if (mix_on)
                begin
                    mi = mul_lo(xc, cos16(s_ff.ph[ch]));
                    mq = -mul_lo(xc, cos16(s_ff.ph[ch] - 4'h4));
                end
                else
                begin
                    mi = xc;
                    mq = '0;
                    if (mode == MODE_REAL_FILT && hp && s_ff.dcnt[0])
                    begin
                        mi = -xc;
                    end
                end
                si = signed'(s_ff.acc_i[ch]) + 18'(mi);
                sq = signed'(s_ff.acc_q[ch]) + 18'(mq);
                if (!mode_legal(mode))
                begin
                    nxt_s.acc_i[ch] = '0;
                    nxt_s.acc_q[ch] = '0;
                end
                else if (s_ff.dcnt >= dec_last)
                begin
                    nxt_s.acc_i[ch] = '0;
                    nxt_s.acc_q[ch] = '0;
                    nxt_s.ovalid[ch] = 1'b1;
                    if (mode == MODE_FINE_DEC4)
                    begin
                        nxt_s.oi[ch] = si[17:2];
                        nxt_s.oq[ch] = sq[17:2];
                    end
                    else if (mode == MODE_PASS)
                    begin
                        nxt_s.oi[ch] = mi;
                        nxt_s.oq[ch] = '0;
                    end
                    else
                    begin
                        nxt_s.oi[ch] = si[16:1];
                        nxt_s.oq[ch] = (mode == MODE_QUARTER || mode == MODE_FINE_CPLX)
                            ? sq[16:1] : 16'h0000;
                    end
                end
                else
                begin
                    nxt_s.acc_i[ch] = si;
                    nxt_s.acc_q[ch] = sq;
                    if (mode == MODE_FINE_ZERO)
                    begin
                        nxt_s.ovalid[ch] = 1'b1;
                        nxt_s.oi[ch] = '0;
                        nxt_s.oq[ch] = '0;
                    end
                end
            end
        end

        // engine reset acts on the falling edge of the pulse and wins over writes
        nxt_s.il_rst_seen = link.interleave_engine_reset;
        if (s_ff.il_rst_seen && !link.interleave_engine_reset)
        begin
            nxt_s.il_byp = RST_CFG;
            nxt_s.dc_loop = RST_CFG;
            nxt_s.il = '0;
            nxt_s.dc = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign link.cfg_rdata = s_ff.rdata;
    assign link.out_valid = s_ff.ovalid;
    assign link.out_i = s_ff.oi;
    assign link.out_q = s_ff.oq;
endmodule : ddc_device

// ===== ddc_cfg_pkg.sv
package ddc_cfg_pkg;
    // device register map: addr[8] selects the decimation page
    localparam int CFG_AW = 9;
    localparam int PAGE_BIT = 8;
    localparam logic [7:0] OFS_MODE_BC = 8'h00;
    localparam logic [7:0] OFS_BC_FILT = 8'h01;
    localparam logic [7:0] OFS_AD = 8'h02;
    localparam logic [7:0] OFS_IL_BYP = 8'h18;
    localparam logic [7:0] OFS_DC_LOOP = 8'h68;
    localparam logic [7:0] MASK_MODE_BC = 8'hff;
    localparam logic [7:0] MASK_BC_FILT = 8'h0f;
    localparam logic [7:0] MASK_AD = 8'h3f;
    localparam logic [7:0] MASK_IL_BYP = 8'h03;
    localparam logic [7:0] MASK_DC_LOOP = 8'h06;
    localparam logic [7:0] RST_CFG = 8'h00;
    // field positions
    localparam int MODE_LSB = 0;
    localparam int BC_TUNE_LSB = 4;
    localparam int BC_COARSE_BIT = 0;
    localparam int BC_HP_BIT = 1;
    localparam int BC_ALWAYS1_BIT = 2;
    localparam int BC_Q6_BIT = 3;
    localparam int AD_TUNE_LSB = 0;
    localparam int AD_COARSE_BIT = 4;
    localparam int AD_HP_BIT = 5;
    localparam int IL_LSB = 0;
    localparam int DC_LSB = 1;
    // mode codes
    localparam logic [3:0] MODE_QUARTER = 4'h0;
    localparam logic [3:0] MODE_REAL_FILT = 4'h2;
    localparam logic [3:0] MODE_FINE_REAL = 4'h4;
    localparam logic [3:0] MODE_FINE_CPLX = 4'h5;
    localparam logic [3:0] MODE_FINE_DEC4 = 4'h6;
    localparam logic [3:0] MODE_FINE_ZERO = 4'h7;
    localparam logic [3:0] MODE_PASS = 4'h8;
    localparam logic [1:0] CORR_ON = 2'b00;
    localparam logic [1:0] CORR_OFF = 2'b11;
    localparam logic [3:0] QUARTER_POS = 4'h4;
    localparam logic [3:0] QUARTER_NEG = 4'hc;
    localparam int DC_SHIFT = 6;
    localparam int IL_SHIFT = 4;
    // controller register map
    localparam int HOST_AW = 3;
    localparam logic [2:0] HOST_OFS_MODE_BC = 3'h0;
    localparam logic [2:0] HOST_OFS_BC_FILT = 3'h1;
    localparam logic [2:0] HOST_OFS_AD = 3'h2;
    localparam logic [2:0] HOST_OFS_CTRL = 3'h3;
    localparam logic [2:0] HOST_OFS_STATUS = 3'h4;
    localparam int CTRL_TEST_BIT = 0;
    localparam int CTRL_ILRST_BIT = 1;

    function automatic logic mode_legal(input logic [3:0] m);
        mode_legal = (m == MODE_QUARTER) || (m == MODE_REAL_FILT) || (m == MODE_FINE_REAL)
            || (m == MODE_FINE_CPLX) || (m == MODE_FINE_DEC4) || (m == MODE_FINE_ZERO)
            || (m == MODE_PASS);
    endfunction : mode_legal

    // magnitude of cos at quadrant offset 4-r
    function automatic logic signed [7:0] cos16_tail(input logic [1:0] r);
        case (r)
            2'd1: cos16_tail = 8'sh31;
            2'd2: cos16_tail = 8'sh5a;
            default: cos16_tail = 8'sh75;
        endcase
    endfunction : cos16_tail

    // cos(2*pi*k/16) scaled by 127
    function automatic logic signed [7:0] cos16(input logic [3:0] k);
        logic [1:0] r;
        logic signed [7:0] mag;
        r = k[1:0];
        case (r)
            2'd0: mag = 8'sh7f;
            2'd1: mag = 8'sh75;
            2'd2: mag = 8'sh5a;
            default: mag = 8'sh31;
        endcase
        case (k[3:2])
            2'd0: cos16 = (r == 2'd0) ? 8'sh7f : mag;
            2'd1: cos16 = (r == 2'd0) ? 8'sh00 : -cos16_tail(r);
            2'd2: cos16 = -mag;
            default: cos16 = (r == 2'd0) ? 8'sh00 : cos16_tail(r);
        endcase
    endfunction : cos16
endpackage : ddc_cfg_pkg

// ===== ddc_link_if.sv
`timescale 1ns/1ps
interface ddc_link_if #(parameter int SMP_W = 14) (input wire logic clk_sys);
    logic [ddc_cfg_pkg::CFG_AW-1:0] cfg_addr;
    logic [7:0] cfg_wdata;
    logic cfg_wr;
    logic cfg_rd;
    logic [7:0] cfg_rdata;
    logic interleave_engine_reset;
    logic smp_valid;
    logic [3:0][SMP_W-1:0] smp;
    logic [3:0] out_valid;
    logic [3:0][15:0] out_i;
    logic [3:0][15:0] out_q;

    modport dev (input cfg_addr, cfg_wdata, cfg_wr, cfg_rd, interleave_engine_reset,
        smp_valid, smp, output cfg_rdata, out_valid, out_i, out_q);
    modport ctl (output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, interleave_engine_reset,
        smp_valid, smp, input cfg_rdata, out_valid, out_i, out_q);
endinterface : ddc_link_if

// ===== ddc_controller.sv
`timescale 1ns/1ps
module ddc_controller #(
    parameter int SMP_W = 14
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ddc_cfg_pkg::HOST_AW-1:0] usr_addr,
    input wire logic [7:0] usr_wdata,
    input wire logic usr_wr,
    input wire logic usr_rd,
    output logic [7:0] usr_rdata,
    output logic usr_busy,
    input wire logic usr_smp_valid,
    input wire logic [3:0][SMP_W-1:0] usr_smp,
    output logic [3:0] usr_out_valid,
    output logic [3:0][15:0] usr_out_i,
    output logic [3:0][15:0] usr_out_q,
    ddc_link_if.ctl link
);
    import ddc_cfg_pkg::*;

    if (SMP_W < 4 || SMP_W > 16)
    begin : gen_bad_smp_w
        $error("SMP_W must be 4..16");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RST_HI = 3'b010,
        ST_RST_LO = 3'b100
    } ctl_state_t;

    typedef struct packed {
        ctl_state_t st;
        logic [7:0] mode_bc;
        logic [7:0] bc_filt;
        logic [7:0] ad;
        logic test_on;
        logic [4:0] pend;
        logic busy;
        logic [7:0] rdata;
        logic [CFG_AW-1:0] caddr;
        logic [7:0] cwdata;
        logic cwr;
        logic il_rst;
        logic svalid;
        logic [3:0][SMP_W-1:0] smp;
        logic [3:0] ovalid;
        logic [3:0][15:0] oi;
        logic [3:0][15:0] oq;
    } ctl_ff_t;

    ctl_ff_t s_ff;
    ctl_ff_t nxt_s;

    always_comb
    begin
        logic [1:0] corr;
        corr = s_ff.test_on ? CORR_OFF : CORR_ON;
        nxt_s = s_ff;
        nxt_s.cwr = 1'b0;
        nxt_s.rdata = '0;
        nxt_s.svalid = usr_smp_valid;
        nxt_s.smp = usr_smp;
        nxt_s.ovalid = link.out_valid;
        nxt_s.oi = link.out_i;
        nxt_s.oq = link.out_q;

        if (usr_wr)
        begin
            case (usr_addr)
                HOST_OFS_MODE_BC:
                begin
                    // illegal mode codes are refused, shadow keeps the old value
                    if (mode_legal(usr_wdata[MODE_LSB +: 4]))
                    begin
                        nxt_s.mode_bc = usr_wdata;
                        nxt_s.pend[1:0] = 2'b11;
                    end
                end
                HOST_OFS_BC_FILT:
                begin
                    nxt_s.bc_filt = usr_wdata & 8'h03;
                    nxt_s.pend[1] = 1'b1;
                end
                HOST_OFS_AD:
                begin
                    nxt_s.ad = usr_wdata & MASK_AD;
                    nxt_s.pend[2] = 1'b1;
                end
                HOST_OFS_CTRL:
                begin
                    nxt_s.test_on = usr_wdata[CTRL_TEST_BIT];
                    nxt_s.pend[4:3] = 2'b11;
                    if (usr_wdata[CTRL_ILRST_BIT] && s_ff.st == ST_IDLE)
                    begin
                        nxt_s.st = ST_RST_HI;
                    end
                end
                default: ;
            endcase
        end
        if (usr_rd)
        begin
            case (usr_addr)
                HOST_OFS_MODE_BC: nxt_s.rdata = s_ff.mode_bc;
                HOST_OFS_BC_FILT: nxt_s.rdata = s_ff.bc_filt;
                HOST_OFS_AD: nxt_s.rdata = s_ff.ad;
                HOST_OFS_CTRL: nxt_s.rdata = {7'h00, s_ff.test_on};
                HOST_OFS_STATUS: nxt_s.rdata = {7'h00, s_ff.busy};
                default: nxt_s.rdata = '0;
            endcase
        end

        case (s_ff.st)
            ST_IDLE:
            begin
                if (s_ff.pend[0])
                begin
                    nxt_s.pend[0] = 1'b0;
                    nxt_s.cwr = 1'b1;
                    nxt_s.caddr = {1'b1, OFS_MODE_BC};
                    nxt_s.cwdata = s_ff.mode_bc;
                end
                else if (s_ff.pend[1])
                begin
                    nxt_s.pend[1] = 1'b0;
                    nxt_s.cwr = 1'b1;
                    nxt_s.caddr = {1'b1, OFS_BC_FILT};
                    nxt_s.cwdata = s_ff.bc_filt;
                    nxt_s.cwdata[BC_ALWAYS1_BIT] = 1'b1;
                    nxt_s.cwdata[BC_Q6_BIT] = (s_ff.mode_bc[MODE_LSB +: 4] == MODE_FINE_DEC4);
                end
                else if (s_ff.pend[2])
                begin
                    nxt_s.pend[2] = 1'b0;
                    nxt_s.cwr = 1'b1;
                    nxt_s.caddr = {1'b1, OFS_AD};
                    nxt_s.cwdata = s_ff.ad;
                end
                else if (s_ff.pend[3])
                begin
                    nxt_s.pend[3] = 1'b0;
                    nxt_s.cwr = 1'b1;
                    nxt_s.caddr = {1'b0, OFS_IL_BYP};
                    nxt_s.cwdata = {6'h00, corr};
                end
                else if (s_ff.pend[4])
                begin
                    nxt_s.pend[4] = 1'b0;
                    nxt_s.cwr = 1'b1;
                    nxt_s.caddr = {1'b0, OFS_DC_LOOP};
                    nxt_s.cwdata = {5'h00, corr, 1'b0};
                end
            end
            ST_RST_HI:
            begin
                nxt_s.il_rst = 1'b1;
                nxt_s.st = ST_RST_LO;
            end
            ST_RST_LO:
            begin
                // the pulse wipes both interleave registers; restore them afterwards
                nxt_s.il_rst = 1'b0;
                nxt_s.pend[4:3] = 2'b11;
                nxt_s.st = ST_IDLE;
            end
            default: nxt_s.st = ST_IDLE;
        endcase
        // registered so the user port sees a flop, same timing as the state it mirrors
        nxt_s.busy = (nxt_s.pend != 5'h00) || (nxt_s.st != ST_IDLE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_ff <= '{st: ST_IDLE, default: '0};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign usr_rdata = s_ff.rdata;
    assign usr_busy = s_ff.busy;
    assign usr_out_valid = s_ff.ovalid;
    assign usr_out_i = s_ff.oi;
    assign usr_out_q = s_ff.oq;
    assign link.cfg_addr = s_ff.caddr;
    assign link.cfg_wdata = s_ff.cwdata;
    assign link.cfg_wr = s_ff.cwr;
    // device readback is not used by this controller
    assign link.cfg_rd = 1'b0;
    assign link.interleave_engine_reset = s_ff.il_rst;
    assign link.smp_valid = s_ff.svalid;
    assign link.smp = s_ff.smp;
endmodule : ddc_controller

// ===== ddc_link_assertions.sv
`timescale 1ns/1ps
module ddc_link_assertions
    import ddc_cfg_pkg::*;
#(
    parameter int SMP_W = 14
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ddc_cfg_pkg::CFG_AW-1:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_rdata,
    input wire logic interleave_engine_reset,
    input wire logic smp_valid,
    input wire logic [3:0][SMP_W-1:0] smp,
    input wire logic [3:0] out_valid,
    input wire logic [3:0][15:0] out_i,
    input wire logic [3:0][15:0] out_q
);
    logic [3:0] mode_ff;
    logic [3:0] nxt_mode;
    logic wr_mode;
    logic wr_bc;
    logic held;
    assign wr_mode = cfg_wr && cfg_addr == 9'h100;
    assign wr_bc = cfg_wr && cfg_addr == 9'h101;
    always_comb
    begin
        nxt_mode = wr_mode ? cfg_wdata[3:0] : mode_ff;
    end
    always_ff @(posedge clk_sys)
    begin
        mode_ff <= rst ? 4'h0 : nxt_mode;
        held <= !rst && nxt_mode == mode_ff;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence il_fall;
        $fell(interleave_engine_reset);
    endsequence
    // reset clears the page, so both fields must be restored in order
    sequence page_rewrite;
        ##[1:3] (cfg_wr && cfg_addr == 9'h018) ##1 (cfg_wr && cfg_addr == 9'h068);
    endsequence
    chk_bc_always_one: assert property (wr_bc |-> cfg_wdata[2])
        else $error("bc filter write lacks bit two");
    chk_q6_qualifier: assert property (
        wr_bc |-> cfg_wdata[3] == (mode_ff == MODE_FINE_DEC4))
        else $error("mode six qualifier wrong");
    chk_mode_legal: assert property (wr_mode |-> mode_legal(cfg_wdata[3:0]))
        else $error("unused mode code sent");
    chk_il_codes: assert property (
        cfg_wr && cfg_addr == 9'h018 |-> cfg_wdata inside {8'h00, 8'h03})
        else $error("bad bypass write");
    chk_dc_codes: assert property (
        cfg_wr && cfg_addr == 9'h068 |-> cfg_wdata inside {8'h00, 8'h06})
        else $error("bad offset loop write");
    chk_pass_rate: assert property (
        held && mode_ff == MODE_PASS && smp_valid |=> out_valid == 4'hf)
        else $error("pass mode dropped a sample");
    chk_real_q_zero: assert property (
        held && out_valid[0] && mode_ff inside {4'h2, 4'h4, 4'h7} |-> out_q[0] == 16'h0000)
        else $error("real mode q not zero");
    chk_dec2_gap: assert property (
        held && out_valid[0] && mode_ff inside {4'h0, 4'h2, 4'h4, 4'h5} |=> !out_valid[0])
        else $error("decimate by two gap missing");
    chk_dec4_gap: assert property (
        held && out_valid[0] && mode_ff == MODE_FINE_DEC4 |=> (!out_valid[0]) [*3])
        else $error("decimate by four gap missing");
    chk_il_rewrite: assert property (il_fall |-> page_rewrite)
        else $error("page not rewritten after reset");
endmodule : ddc_link_assertions

// ===== test_ddc_and_interleave_config.sv
`timescale 1ns/1ps
module test_ddc_and_interleave_config;
    import ddc_cfg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] usr_addr = 3'h0;
    logic [7:0] usr_wdata = 8'h00;
    logic usr_wr = 1'b0;
    logic usr_rd = 1'b0;
    logic usr_smp_valid = 1'b0;
    logic [3:0][13:0] usr_smp = '0;
    logic [7:0] usr_rdata;
    logic usr_busy;
    logic [3:0] usr_out_valid;
    logic [3:0][15:0] usr_out_i;
    logic [3:0][15:0] usr_out_q;
    logic [3:0][15:0] got_i;
    logic [3:0][15:0] got_q;
    int n_out = 0;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    ddc_link_if i_ddc_link_if (.clk_sys(clk_sys));
    ddc_device i_ddc_device (.clk_sys(clk_sys), .rst(rst), .link(i_ddc_link_if));
    ddc_controller i_ddc_controller (.clk_sys(clk_sys), .rst(rst), .usr_addr(usr_addr),
        .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata),
        .usr_busy(usr_busy), .usr_smp_valid(usr_smp_valid), .usr_smp(usr_smp),
        .usr_out_valid(usr_out_valid), .usr_out_i(usr_out_i), .usr_out_q(usr_out_q),
        .link(i_ddc_link_if));
    ddc_link_assertions i_ddc_link_assertions (.clk_sys(clk_sys), .rst(rst),
        .cfg_addr(i_ddc_link_if.cfg_addr), .cfg_wdata(i_ddc_link_if.cfg_wdata),
        .cfg_wr(i_ddc_link_if.cfg_wr), .cfg_rd(i_ddc_link_if.cfg_rd),
        .cfg_rdata(i_ddc_link_if.cfg_rdata),
        .interleave_engine_reset(i_ddc_link_if.interleave_engine_reset),
        .smp_valid(i_ddc_link_if.smp_valid), .smp(i_ddc_link_if.smp),
        .out_valid(i_ddc_link_if.out_valid), .out_i(i_ddc_link_if.out_i),
        .out_q(i_ddc_link_if.out_q));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            final_report();
        end
        for (int c = 0; c < 4; c++)
            if (usr_out_valid[c] === 1'b1)
            begin
                got_i[c] = usr_out_i[c];
                got_q[c] = usr_out_q[c];
                n_out += (c == 0);
            end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        usr_addr <= a;
        usr_wdata <= d;
        usr_wr <= 1'b1;
        @(posedge clk_sys);
        usr_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        usr_addr <= a;
        usr_rd <= 1'b1;
        @(posedge clk_sys);
        usr_rd <= 1'b0;
        @(posedge clk_sys);
        check({8'h00, usr_rdata}, {8'h00, e});
    endtask : rd_chk
    task automatic settle();
        int k = 0;
        repeat (3) @(posedge clk_sys);
        while (usr_busy !== 1'b0 && k < 50)
        begin
            @(posedge clk_sys);
            k++;
        end
        check({15'h0, usr_busy}, 16'h0);
    endtask : settle
    // counts outputs of channel a over eight samples plus a full drain
    task automatic burst(input logic [13:0] v, output int cnt);
        int b = n_out;
        usr_smp <= {4{v}};
        usr_smp_valid <= 1'b1;
        repeat (8) @(posedge clk_sys);
        usr_smp_valid <= 1'b0;
        repeat (8) @(posedge clk_sys);
        cnt = n_out - b;
    endtask : burst
    task automatic t_regs();
        wr(HOST_OFS_MODE_BC, 8'h35);
        wr(HOST_OFS_BC_FILT, 8'hff);
        wr(HOST_OFS_AD, 8'hff);
        wr(HOST_OFS_MODE_BC, 8'h13);
        rd_chk(HOST_OFS_MODE_BC, 8'h35);
        rd_chk(HOST_OFS_BC_FILT, 8'h03);
        rd_chk(HOST_OFS_AD, 8'h3f);
        rd_chk(3'h7, 8'h00);
        settle();
        $display("t_regs done");
    endtask : t_regs
    task automatic t_modes();
        logic [3:0] m[7] = '{4'h8, 4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
        int e[7] = '{8, 4, 4, 4, 4, 2, 8};
        int n;
        wr(HOST_OFS_CTRL, 8'h01);
        foreach (m[k])
        begin
            wr(HOST_OFS_MODE_BC, {4'h0, m[k]});
            settle();
            burst(14'h0100, n);
            check(n[15:0], e[k][15:0]);
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_data();
        int n;
        wr(HOST_OFS_MODE_BC, 8'h08);
        settle();
        burst(14'h3ffb, n);
        check(got_i[2], 16'hfffb);
        wr(HOST_OFS_MODE_BC, 8'h02);
        wr(HOST_OFS_BC_FILT, 8'h02);
        wr(HOST_OFS_AD, 8'h00);
        settle();
        burst(14'h0100, n);
        check(got_i[0], 16'h0100);
        check(got_i[1], 16'h0000);
        check(got_q[0], 16'h0000);
        // n = -8 turns the phase by half a cycle per sample, so each pair cancels
        wr(HOST_OFS_MODE_BC, 8'h85);
        wr(HOST_OFS_AD, 8'h08);
        settle();
        burst(14'h0100, n);
        check(got_i[1], 16'h0000);
        check(got_q[1], 16'h0000);
        check(got_i[3], 16'h0000);
        $display("t_data done");
    endtask : t_data
    task automatic t_ilrst();
        wr(HOST_OFS_CTRL, 8'h03);
        settle();
        rd_chk(HOST_OFS_CTRL, 8'h01);
        rd_chk(HOST_OFS_STATUS, 8'h00);
        $display("t_ilrst done");
    endtask : t_ilrst
    task automatic final_report();
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_modes();
        t_data();
        t_ilrst();
        final_report();
    end
endmodule : test_ddc_and_interleave_config
